// ==== src/dsm_pkg.sv ====
// package for the dsss transmit modulator: register map, fields, resets,
// enumerations, chip timing and the carrier structs.
// assumes a 100 MHz system clock and 8-bit register data.
package dsm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register bus geometry
  localparam int unsigned DSM_AW = 6;
  localparam int unsigned DSM_DW = 8;

  // register addresses
  localparam logic [5:0] DSM_A_ROTATION = 6'h01; // rotation_sense_reg
  localparam logic [5:0] DSM_A_RATE = 6'h05; // tx_rate_select_reg
  localparam logic [5:0] DSM_A_PWR_SET = 6'h1f; // tx_power_setting_reg
  localparam logic [5:0] DSM_A_SCR_DIS = 6'h20; // scrambler_disable_reg
  localparam logic [5:0] DSM_A_SEED_LONG = 6'h24; // long_preamble_seed_reg
  localparam logic [5:0] DSM_A_SEED_SHORT = 6'h25; // short_preamble_seed_reg
  localparam logic [5:0] DSM_A_PWR_MEAS = 6'h3a; // tx_power_measure_reg
  localparam logic [5:0] DSM_A_TAPS = 6'h3c; // scrambler tap mask
  localparam logic [5:0] DSM_A_PKT_CTRL = 6'h3d; // packet control

  // field positions
  localparam int unsigned DSM_F_SCR_DIS = 2;
  localparam int unsigned DSM_F_ROT_TX = 6;
  localparam int unsigned DSM_F_ROT_RX = 7;
  localparam int unsigned DSM_F_SHORT_PRE = 0;

  // reset values
  localparam logic [7:0] DSM_RST_SEED_LONG = 8'h1b;
  localparam logic [7:0] DSM_RST_SEED_SHORT = 8'h6c;
  localparam logic [6:0] DSM_RST_TAPS = 7'h48; // taps at stages 4 and 7
  localparam logic [7:0] DSM_RST_ZERO = 8'h00;

  // barker word, bit k set where chip k is negated, chip 0 sent first
  localparam logic [10:0] DSM_BARKER_NEG = 11'h712;
  localparam logic [3:0] DSM_BARKER_LAST = 4'ha;
  localparam logic [3:0] DSM_CCK_LAST = 4'h7;

  // chip timing: 11 Mchip/s derived from the system clock
  localparam int unsigned DSM_CLK_KHZ = 100000;
  localparam int unsigned DSM_CHIP_KHZ = 11000;
  localparam int unsigned DSM_CHIP_DIV = DSM_CLK_KHZ / DSM_CHIP_KHZ;

  ////////////////////////////////////////////////////////////////////////////
  // payload rate field and packet sections
  typedef enum logic [1:0] {
    DSM_RATE_1M = 2'b00,
    DSM_RATE_2M = 2'b01,
    DSM_RATE_5M5 = 2'b10,
    DSM_RATE_11M = 2'b11
  } dsm_rate_t;

  typedef enum logic [1:0] {
    DSM_SEC_PREAMBLE = 2'b00,
    DSM_SEC_HEADER = 2'b01,
    DSM_SEC_PAYLOAD = 2'b10,
    DSM_SEC_RSVD = 2'b11
  } dsm_sec_t;

  typedef enum logic [1:0] {
    DSM_G_IDLE = 2'b00,
    DSM_G_REQ = 2'b01,
    DSM_G_TAKE = 2'b10,
    DSM_G_FULL = 2'b11
  } dsm_gather_t;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dsm_reg_req_t;

  typedef struct packed {
    logic data;
    dsm_sec_t section;
  } dsm_txbit_t;

  typedef struct packed {
    logic valid;
    logic [1:0] i;
    logic [1:0] q;
  } dsm_chip_t;

endpackage

// ==== src/dsm_modulator.sv ====
// dsss transmit modulator: scrambler, dbpsk/dqpsk barker spreader and cck
// code word generator, with its register file and power reporting.
// assumes the mac presents the next bit on tx_bit and advances it right
// after every edge at which bit_req is high; one clock, reset async low.
//
// Function
// RL1: scramble every section with a self-synchronizing seven-bit shift register.
// RL2: scrambler disable bit set passes bits through unscrambled.
// RL3: output is data xor parity of tapped quotient bits; taps programmable.
// RL4: seed 1b hex long preamble, 6c short; each seed register overrides.
// RL5: repetitive patterns may lock scrambler, any break restarts it.
// RL6: 1 Mbit/s and header bits differentially dbpsk coded, same on i and q.
// RL7: dqpsk dibit first bit earliest: 00 0, 01 +90, 11 +180, 10 -90.
// RL8: rotation counterclockwise; two bits reverse tx and rx sense.
// RL9: rate switches inside a packet: preamble dbpsk, header, payload own.
// RL10: 1 and 2 Mbit/s symbols spread by 11-chip barker on i and q.
// RL11: in 2 Mbit/s one coded bit drives i, the other q.
// RL12: cck symbol is eight complex chips at 11 Mchip/s, chip 0 first.
// RL13: cck phases: p1 all, p2 odd, p3 odd pairs, p4 odd quads; negate 3, 6; code adds p2, p3, p4 at even chips, even pairs, first quad.
// RL14: cck phase one dqpsk, rotating whole symbol; last chip is reference.
// RL15: 5.5 Mbit/s uses nibbles: dibit one to phase one, last two code word.
// RL16: phase one 00 0, 01 pi/2, 11 pi, 10 3pi/2; odd payload adds pi.
// RL17: 5.5 Mbit/s phase two d2 pi plus pi/2, phase three 0, four d3 pi.
// RL18: 11 Mbit/s symbol carries eight bits; first dibit dqpsk phase one.
// RL19: first cck phase one change relative to preceding symbol phase one.
// RL20: 11 Mbit/s dibits two to four give phases two to four, binary.
// RL21: transmit power samples stored in readable power measure register.
// RL22: controller writes desired power level into power setting register.
// RL23: controller picks payload rate: 00 1M, 01 2M, 10 5.5M, 11 11M.
// RL24: short preamble mode sends header at 2 Mbit/s.
// RL25: one chip per chip period with strobe; zero outside packets.
`timescale 1ns/1ns

module dsm_modulator #(
  parameter int unsigned CHIP_DIV = dsm_pkg::DSM_CHIP_DIV
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire dsm_pkg::dsm_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic tx_pe,
  input wire dsm_pkg::dsm_txbit_t tx_bit,
  output logic bit_req,
  output dsm_pkg::dsm_chip_t chip_out,
  input wire logic [7:0] pwr_sample,
  input wire logic pwr_sample_valid,
  output logic [7:0] tx_power_level
);
  import dsm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // dqpsk dibit to quadrant step, first bit in d0
  function automatic logic [1:0] dq_step(input logic d0, input logic d1);
    logic [1:0] s;
    s = {d0, d0 ^ d1};
    return s;
  endfunction

  // cck chip k quadrant from phases one to four
  function automatic logic [1:0] cck_chip(input logic [2:0] k,
                                          input logic [1:0] p1,
                                          input logic [1:0] p2,
                                          input logic [1:0] p3,
                                          input logic [1:0] p4);
    logic [1:0] s;
    s = p1;
    if (!k[0]) s = s + p2; // RL13
    if (!k[1]) s = s + p3; // RL13
    if (!k[2]) s = s + p4; // RL13
    if (k == 3'd3 || k == 3'd6) s = s + 2'd2; // RL13
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [7:0] rot_ff;
  logic [1:0] rate_ff;
  logic [7:0] pwr_set_ff;
  logic [7:0] scr_dis_ff;
  logic [7:0] seed_long_ff;
  logic [7:0] seed_short_ff;
  logic [7:0] pwr_meas_ff;
  logic [6:0] taps_ff;
  logic short_pre_ff;
  logic [7:0] nxt_rdata;

  // software writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rot_ff <= DSM_RST_ZERO;
      rate_ff <= DSM_RATE_1M;
      pwr_set_ff <= DSM_RST_ZERO;
      scr_dis_ff <= DSM_RST_ZERO;
      seed_long_ff <= DSM_RST_SEED_LONG;
      seed_short_ff <= DSM_RST_SEED_SHORT;
      taps_ff <= DSM_RST_TAPS;
      short_pre_ff <= 1'b0;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        DSM_A_ROTATION: rot_ff <= reg_req.wdata; // RL8
        DSM_A_RATE: rate_ff <= reg_req.wdata[1:0]; // RL23
        DSM_A_PWR_SET: pwr_set_ff <= reg_req.wdata; // RL22
        DSM_A_SCR_DIS: scr_dis_ff <= reg_req.wdata; // RL2
        DSM_A_SEED_LONG: seed_long_ff <= reg_req.wdata; // RL4
        DSM_A_SEED_SHORT: seed_short_ff <= reg_req.wdata; // RL4
        DSM_A_TAPS: taps_ff <= reg_req.wdata[6:0]; // RL3
        DSM_A_PKT_CTRL: short_pre_ff <= reg_req.wdata[DSM_F_SHORT_PRE];
        default: ;
      endcase
    end
  end

  // power measurement capture
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwr_meas_ff <= DSM_RST_ZERO;
    end else if (pwr_sample_valid) begin
      pwr_meas_ff <= pwr_sample; // RL21
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    nxt_rdata = 8'h00;
    case (reg_req.addr)
      DSM_A_ROTATION: nxt_rdata = rot_ff;
      DSM_A_RATE: nxt_rdata = {6'h00, rate_ff};
      DSM_A_PWR_SET: nxt_rdata = pwr_set_ff;
      DSM_A_SCR_DIS: nxt_rdata = scr_dis_ff;
      DSM_A_SEED_LONG: nxt_rdata = seed_long_ff;
      DSM_A_SEED_SHORT: nxt_rdata = seed_short_ff;
      DSM_A_PWR_MEAS: nxt_rdata = pwr_meas_ff; // RL21
      DSM_A_TAPS: nxt_rdata = {1'b0, taps_ff};
      DSM_A_PKT_CTRL: nxt_rdata = {7'h00, short_pre_ff};
      default: nxt_rdata = 8'h00;
    endcase
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_req.rd ? nxt_rdata : 8'h00;
    end
  end

  // power level drive
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_power_level <= DSM_RST_ZERO;
    end else begin
      tx_power_level <= pwr_set_ff; // RL22
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // packet start detect and chip rate divider
  logic pe_d_ff;
  logic pkt_start;
  logic [7:0] div_ff;
  logic chip_en;

  assign pkt_start = tx_pe && !pe_d_ff;
  assign chip_en = tx_pe && (div_ff == 8'(CHIP_DIV - 1));

  // edge history of the enable
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pe_d_ff <= 1'b0;
    end else begin
      pe_d_ff <= tx_pe;
    end
  end

  // divider runs only inside packets
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 8'h00;
    end else if (!tx_pe || chip_en) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= div_ff + 8'h01; // RL12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scrambler
  logic [6:0] scr_ff;
  logic scr_out;

  // output is data xor parity of tapped quotient bits; a break in a
  // repeated input pattern reseeds the register with new quotient bits
  assign scr_out = scr_dis_ff[DSM_F_SCR_DIS] ? tx_bit.data : // RL2
                   tx_bit.data ^ (^(scr_ff & taps_ff)); // RL3 RL5

  ////////////////////////////////////////////////////////////////////////////
  // bit gathering
  dsm_gather_t g_state_ff;
  logic [3:0] g_cnt_ff;
  logic [3:0] g_need_ff;
  logic [7:0] g_buf_ff;
  dsm_rate_t g_mode_ff;
  dsm_sec_t g_sec_ff;
  dsm_rate_t next_mode;
  logic load;

  // mode of the symbol about to be gathered
  always_comb begin
    case (tx_bit.section)
      DSM_SEC_PREAMBLE: next_mode = DSM_RATE_1M; // RL9
      DSM_SEC_HEADER: next_mode = short_pre_ff ? DSM_RATE_2M : // RL24
                                  DSM_RATE_1M; // RL6
      DSM_SEC_PAYLOAD: next_mode = dsm_rate_t'(rate_ff); // RL9 RL23
      default: next_mode = DSM_RATE_1M;
    endcase
  end

  // scrambler register holds the last quotient bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scr_ff <= DSM_RST_SEED_LONG[6:0];
    end else if (pkt_start) begin
      scr_ff <= short_pre_ff ? seed_short_ff[6:0] : // RL4
                seed_long_ff[6:0];
    end else if (g_state_ff == DSM_G_TAKE) begin
      scr_ff <= {scr_ff[5:0], scr_out}; // RL1
    end
  end

  // request, take and store bits of one symbol
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      g_state_ff <= DSM_G_IDLE;
      g_cnt_ff <= 4'h0;
      g_need_ff <= 4'h1;
      g_buf_ff <= 8'h00;
      g_mode_ff <= DSM_RATE_1M;
      g_sec_ff <= DSM_SEC_PREAMBLE;
      bit_req <= 1'b0;
    end else if (!tx_pe || pkt_start) begin
      g_state_ff <= DSM_G_IDLE;
      g_cnt_ff <= 4'h0;
      bit_req <= 1'b0;
    end else begin
      bit_req <= 1'b0;
      case (g_state_ff)
        DSM_G_IDLE: begin
          g_mode_ff <= next_mode;
          g_sec_ff <= tx_bit.section;
          g_cnt_ff <= 4'h0;
          g_buf_ff <= 8'h00;
          case (next_mode)
            DSM_RATE_1M: g_need_ff <= 4'h1;
            DSM_RATE_2M: g_need_ff <= 4'h2;
            DSM_RATE_5M5: g_need_ff <= 4'h4; // RL15
            default: g_need_ff <= 4'h8; // RL18
          endcase
          g_state_ff <= DSM_G_REQ;
        end
        DSM_G_REQ: begin
          bit_req <= 1'b1;
          g_state_ff <= DSM_G_TAKE;
        end
        DSM_G_TAKE: begin
          g_buf_ff[g_cnt_ff[2:0]] <= scr_out; // RL7 RL18
          g_cnt_ff <= g_cnt_ff + 4'h1;
          g_state_ff <= (g_cnt_ff + 4'h1 == g_need_ff) ? DSM_G_FULL :
                        DSM_G_REQ;
        end
        DSM_G_FULL: begin
          if (load) begin
            g_state_ff <= DSM_G_IDLE;
          end
        end
        default: g_state_ff <= DSM_G_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // symbol load and chip engine
  logic act_ff;
  logic [3:0] idx_ff;
  dsm_rate_t s_mode_ff;
  logic [1:0] ph_ff;
  logic [1:0] p2_ff;
  logic [1:0] p3_ff;
  logic [1:0] p4_ff;
  logic odd_ff;
  logic [3:0] s_last;
  logic [1:0] nxt_ph;
  logic [1:0] cur_q;

  assign s_last = (s_mode_ff == DSM_RATE_5M5 || s_mode_ff == DSM_RATE_11M) ?
                  DSM_CCK_LAST : DSM_BARKER_LAST;
  assign load = (g_state_ff == DSM_G_FULL) &&
                (!act_ff || (chip_en && idx_ff == s_last));

  // differential phase of the next symbol, relative to the preceding one
  always_comb begin
    case (g_mode_ff)
      DSM_RATE_1M: nxt_ph = ph_ff + {g_buf_ff[0], 1'b0}; // RL6
      DSM_RATE_2M: nxt_ph = ph_ff + dq_step(g_buf_ff[0], g_buf_ff[1]); // RL7
      default: begin
        nxt_ph = ph_ff + dq_step(g_buf_ff[0], g_buf_ff[1]); // RL14 RL16 RL19
        if (g_sec_ff == DSM_SEC_PAYLOAD && odd_ff) begin
          nxt_ph = nxt_ph + 2'd2; // RL16 RL18
        end
      end
    endcase
  end

  // load a gathered symbol and step through its chips
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      act_ff <= 1'b0;
      idx_ff <= 4'h0;
      s_mode_ff <= DSM_RATE_1M;
      ph_ff <= 2'd0;
      p2_ff <= 2'd0;
      p3_ff <= 2'd0;
      p4_ff <= 2'd0;
      odd_ff <= 1'b0;
    end else if (!tx_pe || pkt_start) begin
      act_ff <= 1'b0;
      idx_ff <= 4'h0;
      ph_ff <= 2'd0;
      odd_ff <= 1'b0;
    end else if (load) begin
      act_ff <= 1'b1;
      idx_ff <= 4'h0;
      s_mode_ff <= g_mode_ff; // RL9
      ph_ff <= nxt_ph; // RL14
      if (g_sec_ff == DSM_SEC_PAYLOAD) begin
        odd_ff <= !odd_ff; // RL16
      end
      if (g_mode_ff == DSM_RATE_5M5) begin
        p2_ff <= {g_buf_ff[2], 1'b1}; // RL17
        p3_ff <= 2'd0; // RL17
        p4_ff <= {g_buf_ff[3], 1'b0}; // RL17
      end else begin
        p2_ff <= {g_buf_ff[2], g_buf_ff[3]}; // RL20
        p3_ff <= {g_buf_ff[4], g_buf_ff[5]}; // RL20
        p4_ff <= {g_buf_ff[6], g_buf_ff[7]}; // RL20
      end
    end else if (act_ff && chip_en) begin
      if (idx_ff == s_last) begin
        act_ff <= 1'b0;
      end else begin
        idx_ff <= idx_ff + 4'h1;
      end
    end
  end

  // quadrant of the chip now due
  always_comb begin
    if (s_mode_ff == DSM_RATE_5M5 || s_mode_ff == DSM_RATE_11M) begin
      cur_q = cck_chip(idx_ff[2:0], ph_ff, p2_ff, p3_ff, p4_ff); // RL13 RL14
    end else begin
      cur_q = ph_ff + {DSM_BARKER_NEG[idx_ff], 1'b0}; // RL10 RL11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // chip output: quadrant q is angle 45 + q*90 degrees
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chip_out <= '0;
    end else if (!tx_pe) begin
      chip_out <= '0; // RL25
    end else if (act_ff && chip_en) begin
      chip_out.valid <= 1'b1; // RL25 RL12
      chip_out.i <= (cur_q[1] ^ cur_q[0]) ? 2'b11 : 2'b01; // RL11
      chip_out.q <= (cur_q[1] ^ rot_ff[DSM_F_ROT_TX]) ? 2'b11 : // RL8
                    2'b01; // RL11
    end else begin
      chip_out.valid <= 1'b0;
    end
  end

endmodule // dsm_modulator

// ==== bench/dsm_modulator_assertions.sv ====
// checker for the dsss transmit modulator, port level only.
// assumes one clock domain with async active-low reset; bound to the top.
`timescale 1ns/1ns

module dsm_modulator_checker
  import dsm_pkg::*;
#(
  parameter int unsigned CHIP_DIV = 9
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire dsm_pkg::dsm_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic tx_pe,
  input wire dsm_pkg::dsm_txbit_t tx_bit,
  input wire logic bit_req,
  input wire dsm_pkg::dsm_chip_t chip_out,
  input wire logic [7:0] pwr_sample,
  input wire logic pwr_sample_valid,
  input wire logic [7:0] tx_power_level
);
  import dsm_pkg::*;

  logic [7:0] meas_ff;
  logic [3:0] gap_ff;
  logic seen_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // shadow of the last captured power sample
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) meas_ff <= 8'h00;
    else if (pwr_sample_valid) meas_ff <= pwr_sample;
  end

  // cycles since the last chip strobe, and whether a strobe was seen in this packet
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff <= 4'h0;
      seen_ff <= 1'b0;
    end else begin
      gap_ff <= chip_out.valid ? 4'h0 : gap_ff + 4'h1;
      seen_ff <= tx_pe && (seen_ff || chip_out.valid);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_rd_idle;
    !$past(reg_req.rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside read cycle");

  property p_meas_read;
    $past(reg_req.rd && reg_req.addr == DSM_A_PWR_MEAS)
      |-> reg_rdata == $past(meas_ff);
  endproperty
  a_meas_read: assert property (p_meas_read)
    else $error("power measure read wrong");

  property p_pwr_set;
    reg_req.wr && reg_req.addr == DSM_A_PWR_SET
      |=> ##1 tx_power_level == $past(reg_req.wdata, 2);
  endproperty
  a_pwr_set: assert property (p_pwr_set)
    else $error("power level not taken from write");

  property p_pwr_hold;
    $changed(tx_power_level)
      |-> $past(reg_req.wr && reg_req.addr == DSM_A_PWR_SET, 2);
  endproperty
  a_pwr_hold: assert property (p_pwr_hold)
    else $error("power level changed without write");

  property p_idle_zero;
    !$past(tx_pe) |-> chip_out == '0;
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("chip output not zero outside packet");

  property p_valid_pulse;
    chip_out.valid |=> !chip_out.valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("chip strobe longer than one cycle");

  property p_chip_level;
    chip_out.valid && chip_out.i != 2'b00 |-> chip_out.i[0] && chip_out.q[0];
  endproperty
  a_chip_level: assert property (p_chip_level)
    else $error("chip value not plus or minus one");

  property p_chip_rate;
    chip_out.valid && seen_ff |-> gap_ff == 4'(CHIP_DIV - 1);
  endproperty
  a_chip_rate: assert property (p_chip_rate)
    else $error("chip spacing wrong");

  property p_req_pulse;
    bit_req |=> !bit_req;
  endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("bit request longer than one cycle");

  property p_req_gated;
    !$past(tx_pe) |-> !bit_req;
  endproperty
  a_req_gated: assert property (p_req_gated)
    else $error("bit request outside packet");

  // main scenarios reached
  c_chip: cover property (chip_out.valid && chip_out.i != 2'b00);
  c_meas: cover property (reg_req.rd && reg_req.addr == DSM_A_PWR_MEAS);
  c_req: cover property (bit_req ##2 bit_req);

endmodule // dsm_modulator_checker

bind dsm_modulator dsm_modulator_checker #(.CHIP_DIV(CHIP_DIV))
  i_dsm_modulator_checker (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .reg_req(reg_req),
  .reg_rdata(reg_rdata),
  .tx_pe(tx_pe),
  .tx_bit(tx_bit),
  .bit_req(bit_req),
  .chip_out(chip_out),
  .pwr_sample(pwr_sample),
  .pwr_sample_valid(pwr_sample_valid),
  .tx_power_level(tx_power_level)
);

// ==== bench/dsm_mac_model.sv ====
// transmit bit source standing in for the mac controller.
// assumes the modulator takes tx_bit at each edge with bit_req high.
`timescale 1ns/1ns

module dsm_mac_model
  import dsm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic bit_req,
  output dsm_pkg::dsm_txbit_t tx_bit
);
  import dsm_pkg::*;

  dsm_txbit_t q[$];

  // queue one bit in time order
  task push(input dsm_txbit_t b);
    q.push_back(b);
  endtask

  // advance after each taken bit; when empty the data toggles as junk
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_bit <= '0;
    end else begin
      if (bit_req && q.size() > 0) void'(q.pop_front());
      if (q.size() > 0) tx_bit <= q[0];
      else tx_bit <= {~tx_bit.data, tx_bit.section};
    end
  end

endmodule // dsm_mac_model

// ==== bench/tb_dsm_modulator.sv ====
// self-checking bench for the dsss transmit modulator.
// assumes the mac model supplies bits; chips are compared to a model here.
`timescale 1ns/1ns

module tb_dsm_modulator;
  import dsm_pkg::*;

  typedef struct packed {
    logic [5:0] a;
    logic w;
    logic [7:0] d;
    logic [7:0] e;
  } dsm_row_t;

  logic clk_sys, rst_n, tx_pe, pwr_sample_valid, bit_req;
  logic [7:0] reg_rdata, pwr_sample, tx_power_level, v;
  dsm_reg_req_t reg_req;
  dsm_txbit_t tx_bit;
  dsm_chip_t chip_out;
  int error_cnt, total_checks, cyc;
  dsm_txbit_t src[$];
  logic [3:0] exp_q[$], got_q[$];
  logic [1:0] rate;
  logic shrt, dis, rev;
  logic [7:0] seed;
  dsm_row_t rows[7];

  dsm_modulator #(.CHIP_DIV(DSM_CHIP_DIV)) i_dsm_modulator (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .tx_pe(tx_pe), .tx_bit(tx_bit),
    .bit_req(bit_req), .chip_out(chip_out), .pwr_sample(pwr_sample),
    .pwr_sample_valid(pwr_sample_valid), .tx_power_level(tx_power_level));

  dsm_mac_model i_dsm_mac_model (.clk_sys(clk_sys), .rst_n(rst_n),
    .bit_req(bit_req), .tx_bit(tx_bit));

  ////////////////////////////////////////////////////////////////////////////
  // clock, hang guard and chip capture
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      final_report();
    end
  end
  always @(posedge clk_sys) begin
    if (chip_out.valid && chip_out.i != 2'b00)
      got_q.push_back({chip_out.i, chip_out.q});
  end

  task final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task check(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    reg_req <= '0;
  endtask

  task rd_reg(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    reg_req <= '0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask

  // bits of v, highest first, i.e. in time order
  task add(input dsm_sec_t s, input int n, input logic [15:0] v);
    for (int j = n - 1; j >= 0; j--) begin
      src.push_back({v[j], s});
      i_dsm_mac_model.push({v[j], s});
    end
  endtask

  task cfg(input logic [1:0] r, input logic s, input logic di,
           input logic rv, input logic [7:0] sd);
    rate = r;
    shrt = s;
    dis = di;
    rev = rv;
    seed = sd;
    wr_reg(DSM_A_RATE, {6'h00, r});
    wr_reg(DSM_A_PKT_CTRL, {7'h00, s});
    wr_reg(DSM_A_SCR_DIS, {5'h00, di, 2'b00});
    wr_reg(DSM_A_ROTATION, {1'b0, rv, 6'h00});
    wr_reg(s ? DSM_A_SEED_SHORT : DSM_A_SEED_LONG, sd);
    src.delete();
  endtask

  // quadrant to signed chip pair; reversed sense mirrors q
  function logic [3:0] qmap(input logic [1:0] p);
    return {(p == 2'd0 || p == 2'd3) ? 2'b01 : 2'b11,
            (!p[1] ^ rev) ? 2'b01 : 2'b11};
  endfunction

  // expected chips of the queued packet
  task model();
    logic [6:0] sr;
    logic [7:0] d;
    logic [1:0] ph, p1, p2, p3, p4, p;
    logic s[$];
    int k, n, pay;
    exp_q.delete();
    s.delete();
    sr = seed[6:0];
    foreach (src[j]) begin
      s.push_back(dis ? src[j].data : src[j].data ^ ^(sr & DSM_RST_TAPS));
      sr = {sr[5:0], s[j]};
    end
    k = 0;
    ph = 2'b00;
    pay = 0;
    while (k < s.size()) begin
      n = src[k].section == DSM_SEC_PREAMBLE ? 1 :
          src[k].section == DSM_SEC_HEADER ? (shrt ? 2 : 1) : 1 << rate;
      for (int j = 0; j < n; j++) d[j] = s[k + j];
      if (n < 4) begin
        ph = ph + (n == 1 ? {d[0], 1'b0} : {d[0], d[0] ^ d[1]});
        for (int j = 0; j < 11; j++)
          exp_q.push_back(qmap(ph + {DSM_BARKER_NEG[j], 1'b0}));
      end else begin
        p1 = ph + {d[0], d[0] ^ d[1]} + {pay[0], 1'b0};
        p2 = n == 4 ? {d[2], 1'b1} : {d[2], d[3]};
        p3 = n == 4 ? 2'b00 : {d[4], d[5]};
        p4 = n == 4 ? {d[3], 1'b0} : {d[6], d[7]};
        ph = p1;
        for (int c = 0; c < 8; c++) begin
          p = p1 + (c[0] ? 2'b00 : p2) + (c[1] ? 2'b00 : p3);
          p = p + (c[2] ? 2'b00 : p4) + ((c == 3 || c == 6) ? 2'b10 : 2'b00);
          exp_q.push_back(qmap(p));
        end
      end
      if (src[k].section == DSM_SEC_PAYLOAD) pay++;
      k += n;
    end
  endtask

  // send the queued packet and compare every chip
  task run_pkt(input string nm);
    int n;
    model();
    got_q.delete();
    repeat (2) @(posedge clk_sys);
    tx_pe <= 1'b1;
    n = 0;
    while (got_q.size() < exp_q.size() && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    tx_pe <= 1'b0;
    check(8'(got_q.size()), 8'(exp_q.size()));
    foreach (exp_q[j]) check({4'h0, got_q[j]}, {4'h0, exp_q[j]});
    repeat (3) @(posedge clk_sys);
    check({2'b00, chip_out, bit_req}, 8'h00);
    i_dsm_mac_model.q.delete();
    $display("test %s done", nm);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    tx_pe = 1'b0;
    reg_req = '0;
    pwr_sample = 8'h00;
    pwr_sample_valid = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    cyc = 0;
    rows = '{'{DSM_A_SEED_LONG, 1'b0, 8'h00, 8'h1b},
             '{DSM_A_SEED_SHORT, 1'b0, 8'h00, 8'h6c},
             '{DSM_A_TAPS, 1'b1, 8'hc8, 8'h48},
             '{DSM_A_PWR_MEAS, 1'b1, 8'hff, 8'h3c},
             '{DSM_A_PWR_SET, 1'b1, 8'h5a, 8'h5a},
             '{DSM_A_ROTATION, 1'b1, 8'hc0, 8'hc0},
             '{6'h10, 1'b1, 8'hff, 8'h00}};
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    check(tx_power_level, 8'h00);
    check({2'b00, chip_out, bit_req}, 8'h00);
    pwr_sample <= 8'h3c;
    pwr_sample_valid <= 1'b1;
    @(posedge clk_sys);
    pwr_sample_valid <= 1'b0;
    foreach (rows[j]) begin
      if (rows[j].w) wr_reg(rows[j].a, rows[j].d);
      rd_reg(rows[j].a, v);
      check(v, rows[j].e);
    end
    check(tx_power_level, 8'h5a);
    $display("test registers done");
    cfg(2'b00, 1'b0, 1'b0, 1'b0, 8'h1b);
    add(DSM_SEC_PREAMBLE, 8, 16'h00ff);
    add(DSM_SEC_HEADER, 4, 16'h000a);
    add(DSM_SEC_PAYLOAD, 4, 16'h0006);
    run_pkt("dbpsk");
    cfg(2'b01, 1'b1, 1'b1, 1'b1, 8'h6c);
    add(DSM_SEC_PREAMBLE, 2, 16'h0000);
    add(DSM_SEC_HEADER, 2, 16'h0001);
    add(DSM_SEC_PAYLOAD, 8, 16'h001e);
    run_pkt("dqpsk");
    cfg(2'b10, 1'b0, 1'b0, 1'b0, 8'h1b);
    add(DSM_SEC_PREAMBLE, 1, 16'h0001);
    add(DSM_SEC_HEADER, 1, 16'h0000);
    add(DSM_SEC_PAYLOAD, 12, 16'h05c3);
    run_pkt("cck5");
    cfg(2'b11, 1'b0, 1'b0, 1'b0, 8'h1b);
    add(DSM_SEC_PAYLOAD, 16, 16'h1234);
    @(posedge clk_sys);
    tx_pe <= 1'b1;
    repeat (60) @(posedge clk_sys);
    tx_pe <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check({2'b00, chip_out, bit_req}, 8'h00);
    i_dsm_mac_model.q.delete();
    $display("test abort done");
    cfg(2'b11, 1'b0, 1'b0, 1'b0, 8'h35);
    add(DSM_SEC_HEADER, 2, 16'h0002);
    add(DSM_SEC_PAYLOAD, 16, 16'h9e47);
    run_pkt("cck11");
    final_report();
  end

endmodule // tb_dsm_modulator
